/* File: rtl/mit_pkg.sv */
// Constants, opcodes and carrier types of the instruction execution and timing core.
package mit_pkg;
    localparam int           CLKS_PER_MCYCLE = 4;
    localparam logic [1:0]   PHASE_FETCH     = 2'h0;
    localparam logic [1:0]   PHASE_COMMIT    = 2'h2;
    localparam logic [1:0]   PHASE_LAST      = 2'h3;
    localparam int           PC_W            = 11;
    localparam int           STACK_DEPTH     = 4;
    localparam logic [10:0]  RESET_PC        = 11'h000;
    localparam logic [7:0]   RESET_ACC       = 8'h00;
    localparam logic [1:0]   RESET_SP        = 2'h0;
    localparam logic [7:0]   PCL_ADDR        = 8'h06;
    localparam int           DEST_BIT        = 10;
    localparam int           IMM_BIT         = 9;
    localparam logic [4:0]   OP_NOP          = 5'h00;
    localparam logic [4:0]   OP_MOV_A_M      = 5'h01;
    localparam logic [4:0]   OP_MOV_M_A      = 5'h02;
    localparam logic [4:0]   OP_MOV_A_X      = 5'h03;
    localparam logic [4:0]   OP_ADD          = 5'h04;
    localparam logic [4:0]   OP_ADC          = 5'h05;
    localparam logic [4:0]   OP_SUB          = 5'h06;
    localparam logic [4:0]   OP_SBC          = 5'h07;
    localparam logic [4:0]   OP_CLR_M        = 5'h08;
    localparam logic [4:0]   OP_AND          = 5'h0A;
    localparam logic [4:0]   OP_OR           = 5'h0B;
    localparam logic [4:0]   OP_XOR          = 5'h0C;
    localparam logic [4:0]   OP_CPL          = 5'h0D;
    localparam logic [4:0]   OP_INC          = 5'h0E;
    localparam logic [4:0]   OP_DEC          = 5'h0F;
    localparam logic [4:0]   OP_ROT_R        = 5'h10;
    localparam logic [4:0]   OP_ROT_L        = 5'h11;
    localparam logic [4:0]   OP_ROT_RC       = 5'h12;
    localparam logic [4:0]   OP_ROT_LC       = 5'h13;
    localparam logic [4:0]   OP_SET_BIT      = 5'h14;
    localparam logic [4:0]   OP_CLR_BIT      = 5'h15;
    localparam logic [4:0]   OP_SKIP_Z       = 5'h16;
    localparam logic [4:0]   OP_SKIP_BZ      = 5'h17;
    localparam logic [4:0]   OP_SKIP_BNZ     = 5'h18;
    localparam logic [4:0]   OP_SKIP_INC_Z   = 5'h19;
    localparam logic [4:0]   OP_SKIP_DEC_Z   = 5'h1A;
    localparam logic [4:0]   OP_JUMP         = 5'h1B;
    localparam logic [4:0]   OP_CALL         = 5'h1C;
    localparam logic [4:0]   OP_SUB_RET      = 5'h1D;
    localparam logic [4:0]   OP_INT_RET      = 5'h1E;
    localparam logic [4:0]   OP_TABLE_READ   = 5'h1F;

    typedef enum logic [1:0] {
        MIT_ST_EXEC  = 2'b01,
        MIT_ST_EXTRA = 2'b10
    } mit_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
    } mit_dmem_req_t;

    typedef struct packed {
        logic carry;
        logic zero;
    } mit_flags_t;
endpackage : mit_pkg

/* File: rtl/mit_core.sv */
// Instruction execution and machine-cycle timing core of the small 8-bit controller.
// Function
// - every machine cycle lasts exactly four core clocks.
// - ordinary instructions take one machine cycle; jump, call, returns, table read two.
// - writing the program counter low byte acts as a jump, costing one extra cycle.
// - skip instructions take one cycle, plus one more when the skip happens.
// - moves cover register to accumulator, accumulator to register, immediate to accumulator.
// - addition carries above 255; subtraction flags a borrow below zero.
// - increment and decrement change by one, result to register or accumulator.
// - logic operations write register or accumulator and set zero on zero.
// - rotates shift one bit; through-carry forms exchange the end bit with carry.
// - a call saves the return point; return resumes right after the call.
// - a jump loads the target without saving any return address.
// - conditional branches test a register or bit and skip the next instruction.
// - bit set and clear rewrite the register changing only the chosen bit.
// - table read fetches a program memory word: low byte into a data register, high byte into table_high.
// - interrupt return sets global interrupt enable; subroutine return leaves it.
// - a call pushes program counter plus one, then loads the target.
`timescale 1ns/100ps
module mit_core
    import mit_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    output mit_pkg::mit_dmem_req_t       dmem_req,
    input  wire logic [7:0]              dmem_rdata,
    output logic [mit_pkg::PC_W-1:0]     prog_addr,
    input  wire logic [15:0]             prog_rdata,
    output logic [7:0]                   acc,
    output mit_pkg::mit_flags_t          flags,
    output logic                         global_interrupt_enable,
    input  wire logic                    interrupt_taken,
    output logic [7:0]                   table_high,
    output logic                         instr_start
);
    import mit_pkg::*;

    function automatic logic [7:0] bit_mask(input logic [2:0] sel);
        bit_mask = 8'h01 << sel;
    endfunction : bit_mask

    logic [1:0]       phase;
    logic [1:0]       next_phase;
    mit_state_t       state;
    mit_state_t       next_state;
    logic [15:0]      ir;
    logic [15:0]      next_ir;
    logic [PC_W-1:0]  pc;
    logic [PC_W-1:0]  next_pc;
    logic [PC_W-1:0]  next_prog_addr;
    logic [7:0]       next_acc;
    mit_flags_t       next_flags;
    logic             next_gie;
    logic [7:0]       next_table_high;
    mit_dmem_req_t    next_dmem_req;
    logic [1:0]       sp;
    logic [1:0]       next_sp;
    logic [PC_W-1:0]  stack      [STACK_DEPTH];
    logic [PC_W-1:0]  next_stack [STACK_DEPTH];
    logic             table_pending;
    logic             next_table_pending;
    logic [4:0]       op;
    logic [7:0]       m_val;
    logic [7:0]       src;
    logic [7:0]       mask;
    logic             exec_commit;
    logic [8:0]       sum;
    logic [7:0]       res;
    logic             wr_mem;
    logic             wr_acc;
    logic             upd_zero;
    logic             skip;
    logic             extra;
    logic             cin;

    assign op          = ir[15:11];
    assign m_val       = (ir[7:0] == PCL_ADDR) ? pc[7:0] : dmem_rdata;
    assign src         = ir[IMM_BIT] ? ir[7:0] : m_val;
    assign mask        = bit_mask(ir[10:8]);
    assign exec_commit = (state == MIT_ST_EXEC) && (phase == PHASE_COMMIT);
    assign instr_start = (state == MIT_ST_EXEC) && (phase == PHASE_FETCH);

    always_comb begin
        next_phase         = phase + 2'h1;
        next_state         = state;
        next_ir            = ir;
        next_pc            = pc;
        next_prog_addr     = prog_addr;
        next_acc           = acc;
        next_flags         = flags;
        next_gie           = global_interrupt_enable;
        next_table_high    = table_high;
        next_sp            = sp;
        next_stack         = stack;
        next_table_pending = table_pending;
        next_dmem_req      = '{addr: dmem_req.addr, wdata: dmem_req.wdata, we: 1'b0};
        sum      = 9'h000;
        res      = 8'h00;
        wr_mem   = 1'b0;
        wr_acc   = 1'b0;
        upd_zero = 1'b0;
        skip     = 1'b0;
        extra    = 1'b0;
        cin      = ((op == OP_ADC) || (op == OP_SBC)) ? flags.carry : 1'b0;
        // A set from an interrupt return wins over a simultaneous clear by interrupt entry.
        if (interrupt_taken) begin
            next_gie = 1'b0;
        end
        if ((phase == PHASE_LAST) && (state == MIT_ST_EXEC)) begin
            next_ir       = prog_rdata;
            next_dmem_req = '{addr: prog_rdata[7:0], wdata: dmem_req.wdata, we: 1'b0};
        end
        if (exec_commit) begin
            next_pc        = pc + 11'h001;
            case (op)
                OP_MOV_A_M: begin res = m_val; wr_acc = 1'b1; end
                OP_MOV_M_A: begin res = acc; wr_mem = 1'b1; end
                OP_MOV_A_X: begin res = ir[7:0]; wr_acc = 1'b1; end
                OP_CLR_M:   begin res = 8'h00; wr_mem = 1'b1; end
                OP_ADD, OP_ADC: begin
                    sum = {1'b0, acc} + {1'b0, src} + {8'h00, cin};
                    res = sum[7:0];
                    next_flags.carry = sum[8];
                    upd_zero = 1'b1;
                    wr_mem = ir[DEST_BIT] & ~ir[IMM_BIT];
                    wr_acc = ~wr_mem;
                end
                OP_SUB, OP_SBC: begin
                    sum = {1'b0, acc} - {1'b0, src} - {8'h00, cin};
                    res = sum[7:0];
                    next_flags.carry = sum[8];
                    upd_zero = 1'b1;
                    wr_mem = ir[DEST_BIT] & ~ir[IMM_BIT];
                    wr_acc = ~wr_mem;
                end
                OP_AND, OP_OR, OP_XOR, OP_CPL: begin
                    case (op)
                        OP_AND:  res = acc & src;
                        OP_OR:   res = acc | src;
                        OP_XOR:  res = acc ^ src;
                        default: res = ~m_val;
                    endcase
                    upd_zero = 1'b1;
                    wr_mem = ir[DEST_BIT] & ~ir[IMM_BIT];
                    wr_acc = ~wr_mem;
                end
                OP_INC, OP_DEC: begin
                    res = (op == OP_INC) ? m_val + 8'h01 : m_val - 8'h01;
                    upd_zero = 1'b1;
                    wr_mem = ir[DEST_BIT];
                    wr_acc = ~ir[DEST_BIT];
                end
                OP_ROT_R, OP_ROT_L, OP_ROT_RC, OP_ROT_LC: begin
                    case (op)
                        OP_ROT_R:  res = {m_val[0], m_val[7:1]};
                        OP_ROT_L:  res = {m_val[6:0], m_val[7]};
                        OP_ROT_RC: begin res = {flags.carry, m_val[7:1]}; next_flags.carry = m_val[0]; end
                        default:   begin res = {m_val[6:0], flags.carry}; next_flags.carry = m_val[7]; end
                    endcase
                    wr_mem = ir[DEST_BIT];
                    wr_acc = ~ir[DEST_BIT];
                end
                OP_SET_BIT: begin res = m_val | mask; wr_mem = 1'b1; end
                OP_CLR_BIT: begin res = m_val & ~mask; wr_mem = 1'b1; end
                OP_SKIP_Z:   skip = (m_val == 8'h00);
                OP_SKIP_BZ:  skip = ((m_val & mask) == 8'h00);
                OP_SKIP_BNZ: skip = ((m_val & mask) != 8'h00);
                OP_SKIP_INC_Z, OP_SKIP_DEC_Z: begin
                    res = (op == OP_SKIP_INC_Z) ? m_val + 8'h01 : m_val - 8'h01;
                    skip = (res == 8'h00);
                    wr_mem = ir[DEST_BIT];
                    wr_acc = ~ir[DEST_BIT];
                end
                OP_JUMP: begin
                    next_pc = ir[PC_W-1:0];
                    extra = 1'b1;
                end
                OP_CALL: begin
                    next_stack[sp] = pc + 11'h001;
                    next_sp = sp + 2'h1;
                    next_pc = ir[PC_W-1:0];
                    extra = 1'b1;
                end
                OP_SUB_RET, OP_INT_RET: begin
                    next_sp = sp - 2'h1;
                    next_pc = stack[sp - 2'h1];
                    if (op == OP_INT_RET) begin
                        next_gie = 1'b1;
                    end
                    extra = 1'b1;
                end
                OP_TABLE_READ: begin
                    extra = 1'b1;
                    next_table_pending = 1'b1;
                end
                default: ;
            endcase
            if (upd_zero) begin
                next_flags.zero = (res == 8'h00);
            end
            if (wr_acc) begin
                next_acc = res;
            end
            if (wr_mem && (ir[7:0] == PCL_ADDR)) begin
                next_pc = {pc[PC_W-1:8], res};
                extra = 1'b1;
            end else if (wr_mem) begin
                next_dmem_req = '{addr: dmem_req.addr, wdata: res, we: 1'b1};
            end
            if (skip) begin
                next_pc = pc + 11'h002;
                extra = 1'b1;
            end
            // The table word comes over the program port, so the fetch address is lent to it.
            next_prog_addr = (op == OP_TABLE_READ) ? {pc[PC_W-1:8], acc} : next_pc;
            next_state = extra ? MIT_ST_EXTRA : MIT_ST_EXEC;
        end else if ((state == MIT_ST_EXTRA) && (phase == PHASE_COMMIT)) begin
            if (table_pending) begin
                next_dmem_req = '{addr: dmem_req.addr, wdata: prog_rdata[7:0], we: 1'b1};
                next_table_high = prog_rdata[15:8];
                next_table_pending = 1'b0;
            end
            next_prog_addr = pc;
            next_state = MIT_ST_EXEC;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            phase                   <= PHASE_LAST;
            state                   <= MIT_ST_EXEC;
            ir                      <= 16'h0000;
            pc                      <= RESET_PC;
            prog_addr               <= RESET_PC;
            acc                     <= RESET_ACC;
            flags                   <= '0;
            global_interrupt_enable <= 1'b0;
            table_high              <= 8'h00;
            sp                      <= RESET_SP;
            stack                   <= '{default: RESET_PC};
            table_pending           <= 1'b0;
            dmem_req                <= '0;
        end else begin
            phase                   <= next_phase;
            state                   <= next_state;
            ir                      <= next_ir;
            pc                      <= next_pc;
            prog_addr               <= next_prog_addr;
            acc                     <= next_acc;
            flags                   <= next_flags;
            global_interrupt_enable <= next_gie;
            table_high              <= next_table_high;
            sp                      <= next_sp;
            stack                   <= next_stack;
            table_pending           <= next_table_pending;
            dmem_req                <= next_dmem_req;
        end
    end

    property p_mcycle_four;
        @(posedge core_clk) disable iff (reset) instr_start |=> !instr_start [*3];
    endproperty
    a_mcycle_four: assert property (p_mcycle_four) else $error("Machine cycle shorter than four clocks.");

    property p_normal_one;
        @(posedge core_clk) disable iff (reset) (instr_start && (op == OP_MOV_A_X)) |-> ##4 instr_start;
    endproperty
    a_normal_one: assert property (p_normal_one) else $error("Move took more than one cycle.");

    property p_jump_two;
        @(posedge core_clk) disable iff (reset)
            (instr_start && (op == OP_JUMP)) |-> ##1 !instr_start [*7] ##1 (instr_start && (prog_addr == $past(ir[10:0], 8)));
    endproperty
    a_jump_two: assert property (p_jump_two) else $error("Jump timing or target wrong.");

    property p_pcl_write;
        @(posedge core_clk) disable iff (reset)
            (instr_start && (op == OP_MOV_M_A) && (ir[7:0] == PCL_ADDR)) |-> ##4 !instr_start ##4 instr_start;
    endproperty
    a_pcl_write: assert property (p_pcl_write) else $error("Low program counter write not two cycles.");

    property p_skip_taken;
        @(posedge core_clk) disable iff (reset)
            exec_commit && (op == OP_SKIP_Z) && (m_val == 8'h00) |-> ##2 !instr_start ##4 instr_start;
    endproperty
    a_skip_taken: assert property (p_skip_taken) else $error("Taken skip not two cycles.");

    property p_add_carry;
        @(posedge core_clk) disable iff (reset)
            exec_commit && (op == OP_ADD) && !ir[IMM_BIT] && !ir[DEST_BIT]
            |=> flags.carry == (({1'b0, $past(acc)} + {1'b0, $past(m_val)}) > 9'h0FF);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("Add carry wrong.");

    property p_inc_acc;
        @(posedge core_clk) disable iff (reset)
            exec_commit && (op == OP_INC) && !ir[DEST_BIT] |=> (acc == $past(m_val) + 8'h01) && (flags.zero == (acc == 8'h00));
    endproperty
    a_inc_acc: assert property (p_inc_acc) else $error("Increment result wrong.");

    property p_set_bit;
        @(posedge core_clk) disable iff (reset)
            exec_commit && (op == OP_SET_BIT) && (ir[7:0] != PCL_ADDR)
            |=> dmem_req.we && (dmem_req.wdata == ($past(m_val) | $past(mask)));
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("Bit set changed other bits.");

    property p_call_push;
        @(posedge core_clk) disable iff (reset)
            exec_commit && (op == OP_CALL) |=> (stack[$past(sp)] == $past(pc) + 11'h001) && (sp == $past(sp) + 2'h1);
    endproperty
    a_call_push: assert property (p_call_push) else $error("Call pushed wrong return point.");

    property p_interrupt_return_gie;
        @(posedge core_clk) disable iff (reset) exec_commit && (op == OP_INT_RET) |=> global_interrupt_enable;
    endproperty
    a_interrupt_return_gie: assert property (p_interrupt_return_gie) else $error("Interrupt return left enable clear.");

    property p_ret_gie;
        @(posedge core_clk) disable iff (reset)
            exec_commit && (op == OP_SUB_RET) && !interrupt_taken |=> global_interrupt_enable == $past(global_interrupt_enable);
    endproperty
    a_ret_gie: assert property (p_ret_gie) else $error("Subroutine return changed enable.");

    c_call:  cover property (@(posedge core_clk) disable iff (reset) exec_commit && (op == OP_CALL));
    c_skip:  cover property (@(posedge core_clk) disable iff (reset) exec_commit && (op == OP_SKIP_BZ) && skip);
    c_table: cover property (@(posedge core_clk) disable iff (reset) (state == MIT_ST_EXTRA) && table_pending);
    c_interrupt_return:  cover property (@(posedge core_clk) disable iff (reset) exec_commit && (op == OP_INT_RET));
endmodule : mit_core

/* File: dv/mit_mem_model.sv */
// Program and data memory that sit beside the core, both answering in the same cycle.
`timescale 1ns/100ps
module mit_mem_model
    import mit_pkg::*;
(
    input  wire logic                core_clk,
    input  mit_pkg::mit_dmem_req_t   dmem_req,
    output logic [7:0]               dmem_rdata,
    input  wire logic [mit_pkg::PC_W-1:0] prog_addr,
    output logic [15:0]              prog_rdata
);
    import mit_pkg::*;

    logic [15:0] prog [0:(1<<PC_W)-1];
    logic [7:0]  data [0:255];

    // Reads carry no latency, so table words reach the core within the extra cycle.
    assign prog_rdata = prog[prog_addr];
    assign dmem_rdata = data[dmem_req.addr];

    // The write lands on the edge after the one where the core raises its strobe.
    always @(posedge core_clk) begin
        if (dmem_req.we === 1'b1) begin
            data[dmem_req.addr] <= dmem_req.wdata;
        end
    end
endmodule : mit_mem_model

/* File: dv/testbench.sv */
// Self-checking bench for the execution and timing core.
`timescale 1ns/100ps
module testbench;
    import mit_pkg::*;

    logic               core_clk;
    logic               reset;
    logic               interrupt_taken;
    mit_dmem_req_t      dmem_req;
    logic [7:0]         dmem_rdata;
    logic [PC_W-1:0]    prog_addr;
    logic [15:0]        prog_rdata;
    logic [7:0]         acc;
    mit_flags_t         flags;
    logic               global_interrupt_enable;
    logic [7:0]         table_high;
    logic               instr_start;
    int                 mismatches;
    int                 n_compared;
    int                 gap [32];
    logic [7:0]         acc_at [32];
    logic               c_at [32];
    logic               z_at [32];
    logic               gie_at [32];
    logic [PC_W-1:0]    pa_at [32];

    mit_core mit_core_i (.core_clk(core_clk), .reset(reset), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
        .prog_addr(prog_addr), .prog_rdata(prog_rdata), .acc(acc), .flags(flags),
        .global_interrupt_enable(global_interrupt_enable), .interrupt_taken(interrupt_taken),
        .table_high(table_high), .instr_start(instr_start));
    mit_mem_model mit_mem_model_i (.core_clk(core_clk), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
        .prog_addr(prog_addr), .prog_rdata(prog_rdata));

    always #4 core_clk = ~core_clk;

    function automatic logic [15:0] w(input logic [4:0] op, input logic [2:0] hi, input logic [7:0] lo);
        return {op, hi, lo};
    endfunction : w

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Holding reset while the memories are rewritten keeps the core from storing into them.
    task automatic fresh();
        reset = 1'b1;
        for (int i = 0; i < (1 << PC_W); i++) mit_mem_model_i.prog[i] = 16'h0000;
        for (int i = 0; i < 256; i++) mit_mem_model_i.data[i] = 8'h00;
    endtask : fresh

    // Records state at each instruction start; gap[k] is the core clock count that ended at start k.
    task automatic run(input int n, input int irq_k);
        int cnt;
        repeat (3) @(negedge core_clk);
        reset = 1'b0;
        for (int k = 0; k < n; k++) begin
            cnt = 0;
            do begin
                @(negedge core_clk);
                interrupt_taken = 1'b0;
                cnt++;
            end while (instr_start !== 1'b1 && cnt < 24);
            if (instr_start !== 1'b1) begin
                mismatches++;
                end_of_test();
            end
            gap[k] = cnt;
            acc_at[k] = acc;
            c_at[k] = flags.carry;
            z_at[k] = flags.zero;
            gie_at[k] = global_interrupt_enable;
            pa_at[k] = prog_addr;
            if (k == irq_k) interrupt_taken = 1'b1;
        end
    endtask : run

    task automatic timing_and_skips();
        int eg [11] = '{4, 4, 4, 8, 8, 4, 8, 8, 8, 8, 4};
        // Slots that must never execute: dropped fetches after transfers and skipped words.
        logic [PC_W-1:0] sk [6] = '{11'h004, 11'h011, 11'h014, 11'h031, 11'h033, 11'h035};
        fresh();
        mit_mem_model_i.data[8'h23] = 8'hFF;
        mit_mem_model_i.prog[11'h000] = w(OP_MOV_A_X, 3'h0, 8'h05);
        mit_mem_model_i.prog[11'h001] = w(OP_MOV_M_A, 3'h0, 8'h20);
        mit_mem_model_i.prog[11'h002] = w(OP_SKIP_Z, 3'h0, 8'h20);
        mit_mem_model_i.prog[11'h003] = w(OP_JUMP, 3'h0, 8'h10);
        mit_mem_model_i.prog[11'h010] = w(OP_SKIP_Z, 3'h0, 8'h21);
        mit_mem_model_i.prog[11'h012] = w(OP_MOV_A_X, 3'h0, 8'h30);
        mit_mem_model_i.prog[11'h013] = w(OP_MOV_M_A, 3'h0, PCL_ADDR);
        mit_mem_model_i.prog[11'h030] = w(OP_SKIP_BNZ, 3'h0, 8'h20);
        mit_mem_model_i.prog[11'h032] = w(OP_SKIP_BZ, 3'h1, 8'h20);
        mit_mem_model_i.prog[11'h034] = w(OP_SKIP_INC_Z, 3'h4, 8'h23);
        mit_mem_model_i.prog[11'h036] = w(OP_SKIP_DEC_Z, 3'h4, 8'h20);
        foreach (sk[i]) mit_mem_model_i.prog[sk[i]] = w(OP_MOV_M_A, 3'h0, 8'h22);
        run(12, -1);
        for (int k = 0; k < 11; k++) check(16'(gap[k + 1]), 16'(eg[k]));
        check(pa_at[5], 11'h012);
        check(pa_at[7], 11'h030);
        check(pa_at[11], 11'h037);
        check(mit_mem_model_i.data[8'h22], 8'h00);
        check(mit_mem_model_i.data[8'h20], 8'h04);
        check(mit_mem_model_i.data[8'h23], 8'h00);
    endtask : timing_and_skips

    task automatic alu_ops();
        logic [7:0] ea [19] = '{8'hC8, 8'h08, 8'h09, 8'hFF, 8'hFE, 8'h00, 8'h81, 8'h00, 8'hF0, 8'hE0,
                                8'hF8, 8'hE1, 8'h78, 8'h21, 8'h21, 8'h21, 8'h21, 8'h61, 8'h61};
        logic [15:0] pg [19] = '{w(OP_MOV_A_X, 3'h0, 8'hC8), w(OP_ADD, 3'h2, 8'h40), w(OP_ADD, 3'h2, 8'h01),
            w(OP_SUB, 3'h2, 8'h0A), w(OP_SUB, 3'h2, 8'h01), w(OP_AND, 3'h2, 8'h00), w(OP_OR, 3'h2, 8'h81),
            w(OP_XOR, 3'h2, 8'h81), w(OP_MOV_A_M, 3'h0, 8'h40), w(OP_ROT_LC, 3'h0, 8'h40),
            w(OP_ROT_RC, 3'h0, 8'h40), w(OP_ROT_L, 3'h0, 8'h40), w(OP_ROT_R, 3'h0, 8'h40),
            w(OP_INC, 3'h0, 8'h41), w(OP_DEC, 3'h4, 8'h41), w(OP_SET_BIT, 3'h7, 8'h41),
            w(OP_CLR_BIT, 3'h0, 8'h41), w(OP_CPL, 3'h0, 8'h41), w(OP_MOV_M_A, 3'h0, 8'h42)};
        fresh();
        mit_mem_model_i.data[8'h40] = 8'hF0;
        mit_mem_model_i.data[8'h41] = 8'h20;
        foreach (pg[i]) mit_mem_model_i.prog[i] = pg[i];
        run(20, -1);
        for (int k = 0; k < 19; k++) check(acc_at[k + 1], ea[k]);
        for (int k = 0; k < 19; k++) check(16'(gap[k + 1]), 16'h0004);
        check({c_at[2], c_at[3], c_at[4], c_at[5], c_at[10], c_at[11]}, 6'b101010);
        check({z_at[6], z_at[7], z_at[8], z_at[18]}, 4'b1010);
        check(mit_mem_model_i.data[8'h41], 8'h9E);
        check(mit_mem_model_i.data[8'h40], 8'hF0);
        check(mit_mem_model_i.data[8'h42], 8'h61);
    endtask : alu_ops

    task automatic calls_and_tables();
        int eg [7] = '{8, 8, 8, 8, 4, 8, 8};
        fresh();
        mit_mem_model_i.prog[11'h000] = w(OP_CALL, 3'h1, 8'h00);
        mit_mem_model_i.prog[11'h100] = w(OP_INT_RET, 3'h0, 8'h00);
        mit_mem_model_i.prog[11'h001] = w(OP_CALL, 3'h1, 8'h08);
        mit_mem_model_i.prog[11'h108] = w(OP_SUB_RET, 3'h0, 8'h00);
        mit_mem_model_i.prog[11'h002] = w(OP_MOV_A_X, 3'h0, 8'h80);
        mit_mem_model_i.prog[11'h003] = w(OP_TABLE_READ, 3'h0, 8'h50);
        mit_mem_model_i.prog[11'h004] = w(OP_JUMP, 3'h2, 8'h00);
        mit_mem_model_i.prog[11'h080] = 16'hBEEF;
        run(8, 4);
        for (int k = 0; k < 7; k++) check(16'(gap[k + 1]), 16'(eg[k]));
        check(pa_at[1], 11'h100);
        check(pa_at[2], 11'h001);
        check(pa_at[4], 11'h002);
        check(pa_at[7], 11'h200);
        check({gie_at[0], gie_at[2], gie_at[4], gie_at[6]}, 4'b0110);
        check(mit_mem_model_i.data[8'h50], 8'hEF);
        check(table_high, 8'hBE);
        check(acc_at[7], 8'h80);
    endtask : calls_and_tables

    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        interrupt_taken = 1'b0;
        mismatches = 0;
        n_compared = 0;
        timing_and_skips();
        alu_ops();
        calls_and_tables();
        end_of_test();
    end
endmodule : testbench
